// ==== inc/cpu_machine_cycle_bus_sequencer_defines.vh ====
`ifndef CPU_MACHINE_CYCLE_BUS_SEQUENCER_DEFINES_VH
`define CPU_MACHINE_CYCLE_BUS_SEQUENCER_DEFINES_VH

// ****************************************
// Register byte offsets
// ****************************************
`define OFS_CMD 8'h00
`define OFS_ADDR 8'h04
`define OFS_WDATA 8'h08
`define OFS_CTRL 8'h0C
`define OFS_STATUS 8'h10
`define OFS_RDATA 8'h14
`define OFS_PC 8'h18

// ****************************************
// Command register fields
// ****************************************
`define CMD_TYPE_HI 3
`define CMD_TYPE_LO 0
`define CMD_NEED_T4 4
`define CMD_NEED_T5 5
`define CMD_LAST 6
`define CMD_PEND 7
`define CMD_W 7
`define CMD_RESET 7'h00

// ****************************************
// Control and status fields
// ****************************************
`define CTRL_IRQ_EN 0
`define STAT_BUSY 7
`define STAT_IRQ_LATCH 8
`define STAT_HOLD 9
`define STAT_HALTED 10
`define STAT_DONE 11

// ****************************************
// Machine cycle types
// ****************************************
`define MC_FETCH 4'h0
`define MC_MEM_RD 4'h1
`define MC_MEM_WR 4'h2
`define MC_STK_RD 4'h3
`define MC_STK_WR 4'h4
`define MC_INPUT 4'h5
`define MC_OUTPUT 4'h6
`define MC_INT_ACK 4'h7
`define MC_HALT_ACK 4'h8

// ****************************************
// Status word bits and words
// ****************************************
`define SB_IRQ_ACK 0
`define SB_DIR_N 1
`define SB_STACK 2
`define SB_HALT_ACK 3
`define SB_PORT_WR 4
`define SB_FETCH 5
`define SB_PORT_RD 6
`define SB_MEM_RD 7
`define SW_FETCH 8'hA2
`define SW_MEM_RD 8'h82
`define SW_MEM_WR 8'h00
`define SW_STK_RD 8'h86
`define SW_STK_WR 8'h04
`define SW_INPUT 8'h42
`define SW_OUTPUT 8'h10
`define SW_INT_ACK 8'h23
`define SW_HALT_ACK 8'h8A

// ****************************************
// Sequencer states, one-hot
// ****************************************
`define ST_W 7
`define ST_IDLE 7'h01
`define ST_T1 7'h02
`define ST_T2 7'h04
`define ST_WAIT 7'h08
`define ST_T3 7'h10
`define ST_T4 7'h20
`define ST_T5 7'h40

// ****************************************
// Misc
// ****************************************
`define ONE16 16'h0001
`define ZERO32 32'h00000000

`endif

// ==== src/cpu_machine_cycle_bus_sequencer.v ====
`timescale 1ns/1ps
`include "cpu_machine_cycle_bus_sequencer_defines.vh"

module cpu_machine_cycle_bus_sequencer (
    input wire hclk,
    input wire hresetn,
    input wire hsel,
    input wire [31:0] haddr,
    input wire [1:0] htrans,
    input wire hwrite,
    input wire [2:0] hsize,
    input wire [31:0] hwdata,
    input wire hready,
    output reg [31:0] hrdata,
    output reg hreadyout,
    output reg hresp,
    input wire ready,
    input wire hold_req,
    input wire irq_req,
    input wire [7:0] data_in,
    output reg [15:0] addr_out,
    output reg [7:0] data_out,
    output reg data_oe,
    output reg sync_out,
    output reg data_in_strobe,
    output reg wr_n,
    output reg wait_out,
    output reg irq_enable_flag
);

    // ****************************************
    // Decode helpers
    // ****************************************
    function [7:0] status_of;
        input [3:0] t;
        begin
            case (t)
                `MC_FETCH: status_of = `SW_FETCH;
                `MC_MEM_RD: status_of = `SW_MEM_RD;
                `MC_MEM_WR: status_of = `SW_MEM_WR;
                `MC_STK_RD: status_of = `SW_STK_RD;
                `MC_STK_WR: status_of = `SW_STK_WR;
                `MC_INPUT: status_of = `SW_INPUT;
                `MC_OUTPUT: status_of = `SW_OUTPUT;
                `MC_INT_ACK: status_of = `SW_INT_ACK;
                `MC_HALT_ACK: status_of = `SW_HALT_ACK;
                default: status_of = `SW_FETCH;
            endcase
        end
    endfunction

    function strobe_type;
        input [3:0] t;
        begin
            // Input and halt cycles read without the strobe
            strobe_type = (t == `MC_FETCH) || (t == `MC_MEM_RD) ||
                          (t == `MC_STK_RD) || (t == `MC_INT_ACK);
        end
    endfunction

    function uses_pc;
        input [3:0] t;
        begin
            uses_pc = (t == `MC_FETCH) || (t == `MC_INT_ACK);
        end
    endfunction

    // ****************************************
    // Pin synchronisers
    // ****************************************
    reg [10:0] pin_s1_q;
    reg [10:0] pin_s2_q;
    wire [7:0] din_s = pin_s2_q[7:0];
    wire ready_s = pin_s2_q[8];
    wire hold_s = pin_s2_q[9];
    wire irq_s = pin_s2_q[10];

    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            pin_s1_q <= 11'h000;
            pin_s2_q <= 11'h000;
        end else begin
            pin_s1_q <= {irq_req, hold_req, ready, data_in};
            pin_s2_q <= pin_s1_q;
        end
    end

    // ****************************************
    // Phase enables
    // ****************************************
    reg ph_q;
    wire phi1_en = !ph_q;
    wire phi2_en = ph_q;

    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ph_q <= 1'b0;
        end else begin
            ph_q <= !ph_q;
        end
    end

    // ****************************************
    // State declarations
    // ****************************************
    localparam [6:0] S_IDLE = `ST_IDLE;
    localparam [6:0] S_T1 = `ST_T1;
    localparam [6:0] S_T2 = `ST_T2;
    localparam [6:0] S_WAIT = `ST_WAIT;
    localparam [6:0] S_T3 = `ST_T3;
    localparam [6:0] S_T4 = `ST_T4;
    localparam [6:0] S_T5 = `ST_T5;

    reg [`ST_W-1:0] state_q;
    reg [3:0] cur_type_q;
    reg need_t4_q;
    reg need_t5_q;
    reg last_q;
    reg ready_q;
    reg hold_q;
    reg halted_q;
    reg irq_latch_q;
    reg done_q;
    reg [15:0] pc_q;
    reg [7:0] rdata_q;

    reg [`CMD_W-1:0] cmd_q;
    reg pend_q;
    reg [15:0] addr_q;
    reg [7:0] wdata_q;
    reg wr_q;
    reg [7:0] wa_q;

    wire [3:0] cmd_type = cmd_q[`CMD_TYPE_HI:`CMD_TYPE_LO];
    wire [7:0] cur_status = status_of(cur_type_q);
    wire cur_read = cur_status[`SB_DIR_N];
    wire cur_halt = cur_type_q == `MC_HALT_ACK;
    wire end_now = (state_q == S_T3 && !need_t4_q) ||
                   (state_q == S_T4 && !need_t5_q) || (state_q == S_T5);
    wire take = phi1_en && pend_q && (state_q == S_IDLE || end_now);
    wire to_ack = irq_latch_q && cmd_type == `MC_FETCH;
    wire [3:0] launch_type = to_ack ? `MC_INT_ACK : cmd_type;
    wire wr_cmd = wr_q && wa_q == `OFS_CMD;
    wire wr_ctrl = wr_q && wa_q == `OFS_CTRL;
    wire wr_stat = wr_q && wa_q == `OFS_STATUS;
    wire wr_pc = wr_q && wa_q == `OFS_PC;
    wire irq_take = irq_s && irq_enable_flag;

    // ****************************************
    // Machine cycle sequencer
    // ****************************************
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            state_q <= S_IDLE;
            cur_type_q <= `MC_FETCH;
            need_t4_q <= 1'b0;
            need_t5_q <= 1'b0;
            last_q <= 1'b0;
            ready_q <= 1'b1;
            hold_q <= 1'b0;
            halted_q <= 1'b0;
            irq_latch_q <= 1'b0;
            irq_enable_flag <= 1'b0;
            done_q <= 1'b0;
            pc_q <= 16'h0000;
            rdata_q <= 8'h00;
            addr_out <= 16'h0000;
            data_out <= 8'h00;
            data_oe <= 1'b0;
            sync_out <= 1'b0;
            data_in_strobe <= 1'b0;
            wr_n <= 1'b1;
            wait_out <= 1'b0;
        end else begin
            if (wr_ctrl) begin
                irq_enable_flag <= hwdata[`CTRL_IRQ_EN];
            end
            if (wr_stat && hwdata[`STAT_DONE]) begin
                done_q <= 1'b0;
            end
            if (wr_pc) begin
                pc_q <= hwdata[15:0];
            end
            if (phi1_en) begin
                // Phase one moves the state
                case (state_q)
                    S_IDLE: begin
                        state_q <= S_IDLE;
                    end
                    S_T1: begin
                        state_q <= S_T2;
                    end
                    S_T2: begin
                        if (!cur_read) begin
                            wr_n <= 1'b0;
                        end
                        if (!ready_q || cur_halt) begin
                            state_q <= S_WAIT;
                            wait_out <= 1'b1;
                            halted_q <= cur_halt;
                        end else begin
                            state_q <= S_T3;
                        end
                    end
                    S_WAIT: begin
                        if (cur_halt) begin
                            // Only an enabled interrupt ends the halt wait
                            if (irq_take) begin
                                state_q <= S_IDLE;
                                wait_out <= 1'b0;
                                halted_q <= 1'b0;
                                irq_latch_q <= 1'b1;
                            end
                        end else if (ready_q) begin
                            state_q <= S_T3;
                            wait_out <= 1'b0;
                        end
                    end
                    S_T3: begin
                        wr_n <= 1'b1;
                        state_q <= need_t4_q ? S_T4 : S_IDLE;
                    end
                    S_T4: begin
                        state_q <= need_t5_q ? S_T5 : S_IDLE;
                    end
                    S_T5: begin
                        state_q <= S_IDLE;
                    end
                    default: begin
                        state_q <= S_IDLE;
                    end
                endcase
                if (end_now) begin
                    done_q <= 1'b1;
                end
                if (take) begin
                    state_q <= S_T1;
                    cur_type_q <= launch_type;
                    need_t4_q <= cmd_q[`CMD_NEED_T4];
                    need_t5_q <= cmd_q[`CMD_NEED_T5];
                    last_q <= cmd_q[`CMD_LAST];
                    if (to_ack) begin
                        irq_latch_q <= 1'b0;
                        irq_enable_flag <= 1'b0;
                    end
                end
            end
            if (phi2_en) begin
                // Phase two times the address, status, data and read strobe events; wr_n and wait_out move in phase one
                case (state_q)
                    S_T1: begin
                        addr_out <= uses_pc(cur_type_q) ? pc_q : addr_q;
                        data_out <= cur_status;
                        data_oe <= 1'b1;
                        sync_out <= 1'b1;
                    end
                    S_T2: begin
                        sync_out <= 1'b0;
                        ready_q <= ready_s;
                        hold_q <= hold_s;
                        if (cur_read) begin
                            data_oe <= 1'b0;
                            data_in_strobe <= strobe_type(cur_type_q);
                        end else begin
                            data_out <= wdata_q;
                        end
                        if (cur_type_q == `MC_FETCH) begin
                            pc_q <= pc_q + `ONE16;
                        end
                    end
                    S_WAIT: begin
                        ready_q <= ready_s;
                        hold_q <= hold_s;
                    end
                    S_T3: begin
                        if (cur_read) begin
                            rdata_q <= din_s;
                        end
                        data_in_strobe <= 1'b0;
                    end
                    default: begin
                        sync_out <= 1'b0;
                    end
                endcase
                if (end_now && last_q && irq_take) begin
                    irq_latch_q <= 1'b1;
                end
            end
        end
    end

    // ****************************************
    // AHB-Lite slave
    // ****************************************
    reg [31:0] rmux;

    always @* begin
        rmux = `ZERO32;
        case (haddr[7:0])
            `OFS_CMD: rmux = {24'h000000, pend_q, cmd_q};
            `OFS_ADDR: rmux = {16'h0000, addr_q};
            `OFS_WDATA: rmux = {24'h000000, wdata_q};
            `OFS_CTRL: rmux = {31'h00000000, irq_enable_flag};
            `OFS_STATUS: rmux = {20'h00000, done_q, halted_q, hold_q, irq_latch_q,
                                 pend_q || state_q != S_IDLE, state_q};
            `OFS_RDATA: rmux = {24'h000000, rdata_q};
            `OFS_PC: rmux = {16'h0000, pc_q};
            default: rmux = `ZERO32;
        endcase
    end

    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata <= `ZERO32;
            hreadyout <= 1'b1;
            hresp <= 1'b0;
            wr_q <= 1'b0;
            wa_q <= 8'h00;
            cmd_q <= `CMD_RESET;
            pend_q <= 1'b0;
            addr_q <= 16'h0000;
            wdata_q <= 8'h00;
        end else begin
            // No wait states: every transfer answers OKAY at once
            hreadyout <= 1'b1;
            hresp <= 1'b0;
            if (hready) begin
                wr_q <= hsel && htrans[1] && hwrite;
                wa_q <= haddr[7:0];
                if (hsel && htrans[1] && !hwrite) begin
                    hrdata <= rmux;
                end
            end
            if (wr_cmd) begin
                cmd_q <= hwdata[`CMD_W-1:0];
            end
            if (wr_q && wa_q == `OFS_ADDR) begin
                addr_q <= hwdata[15:0];
            end
            if (wr_q && wa_q == `OFS_WDATA) begin
                wdata_q <= hwdata[7:0];
            end
            // A new command wins over the launch of the old one
            if (wr_cmd) begin
                pend_q <= 1'b1;
            end else if (take) begin
                pend_q <= 1'b0;
            end
        end
    end

endmodule

// ==== dv/cpu_seq_monitor.sv ====
`timescale 1ns/1ps
// ****
// Bus sequencer checks
// ****
module cpu_seq_monitor (
    input wire hclk,
    input wire hresetn,
    input wire hreadyout,
    input wire hresp,
    input wire [15:0] addr_out,
    input wire [7:0] data_out,
    input wire data_oe,
    input wire sync_out,
    input wire data_in_strobe,
    input wire wr_n,
    input wire wait_out,
    input wire irq_enable_flag
);
    reg [7:0] st_q;
    // Halt ack carries the read bit but never strobes
    wire rd_kind = (st_q[7] & ~st_q[3]) | st_q[0];
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn)
            st_q <= 8'h00;
        else if (sync_out)
            st_q <= data_out;
    end
    default clocking @(posedge hclk); endclocking
    default disable iff (!hresetn);
    bus_okay_a: assert property (hreadyout && !hresp)
        else $error("bus answer not zero-wait okay");
    sync_len_a: assert property ($rose(sync_out) |=> sync_out ##1 !sync_out)
        else $error("cycle marker not one state long");
    status_on_a: assert property (sync_out |-> data_oe)
        else $error("status not driven in first state");
    ack_fetch_a: assert property (
        sync_out && data_out[0] |-> data_out[5] && !irq_enable_flag)
        else $error("acknowledge word lacks fetch bit");
    addr_hold_a: assert property ($fell(sync_out) |-> $stable(addr_out))
        else $error("address moved in second state");
    strobe_rise_a: assert property (
        $rose(data_in_strobe) |-> $fell(sync_out) && !data_oe)
        else $error("read strobe rose off second state");
    strobe_kind_a: assert property (data_in_strobe |-> rd_kind)
        else $error("read strobe in wrong cycle");
    strobe_wait_a: assert property (wait_out && rd_kind |-> data_in_strobe)
        else $error("read strobe dropped in wait");
    wr_kind_a: assert property (
        !wr_n |-> !st_q[1] && data_oe && $stable(data_out))
        else $error("write strobe misplaced");
    wr_start_a: assert property ($fell(wr_n) |-> $past(sync_out, 2))
        else $error("write strobe not after second state");
    wait_start_a: assert property ($rose(wait_out) |-> $past(sync_out, 2))
        else $error("wait not after second state");
endmodule

bind cpu_machine_cycle_bus_sequencer cpu_seq_monitor u_cpu_seq_monitor (
    .hclk(hclk), .hresetn(hresetn), .hreadyout(hreadyout), .hresp(hresp),
    .addr_out(addr_out), .data_out(data_out), .data_oe(data_oe), .sync_out(sync_out),
    .data_in_strobe(data_in_strobe), .wr_n(wr_n), .wait_out(wait_out),
    .irq_enable_flag(irq_enable_flag)
);

// ==== dv/bus_partner.sv ====
`timescale 1ns/1ps
// ****
// Far-side memory and ports
// ****
module bus_partner (
    input wire hclk,
    input wire hresetn,
    input wire slow,
    input wire [2:0] rst_sel,
    input wire [15:0] addr_out,
    input wire [7:0] data_out,
    input wire sync_out,
    input wire wr_n,
    input wire wait_out,
    output reg ready,
    output wire [7:0] data_in,
    output reg [7:0] wr_byte
);
    reg [7:0] st_q;
    reg [7:0] last_q;
    reg [1:0] wcnt_q;
    // Restart opcode jammed on acknowledge, vector is eight times the field
    wire [7:0] val = st_q[0] ? {2'b11, rst_sel, 3'b111} :
                     addr_out[7:0] ^ 8'h3C;
    wire drive = st_q[7] | st_q[6] | st_q[0];
    // Released bus shows a changing value, the inverse of the old byte and the old byte in turn
    assign data_in = drive ? val : ~last_q;
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            st_q <= 8'h00;
            last_q <= 8'h00;
            wcnt_q <= 2'h0;
            ready <= 1'b1;
            wr_byte <= 8'h00;
        end else begin
            if (sync_out)
                st_q <= data_out;
            if (drive)
                last_q <= val;
            else
                last_q <= ~last_q;
            wcnt_q <= wait_out ? wcnt_q + {1'b0, wcnt_q != 2'h3} : 2'h0;
            ready <= !slow || wcnt_q == 2'h3;
            if (!wr_n)
                wr_byte <= data_out;
        end
    end
endmodule

// ==== dv/testbench.sv ====
`timescale 1ns/1ps
`include "cpu_machine_cycle_bus_sequencer_defines.vh"
// ****
// Self-checking bench
// ****
module testbench;
    reg hclk, hresetn, hsel, hwrite, irq_req, hold_req, slow;
    reg [31:0] haddr, hwdata, rv, pc, ad, wd, r;
    reg [1:0] htrans;
    reg [2:0] rst_sel;
    reg [15:0] a16;
    reg sync_d;
    wire [31:0] hrdata;
    wire [15:0] addr_out;
    wire [7:0] data_out, data_in, wr_byte;
    wire hreadyout, hresp, ready, data_oe, sync_out, data_in_strobe;
    wire wr_n, wait_out, irq_enable_flag;
    integer failures = 0, num_checks = 0, t, i;
    reg [31:0] rq[$];
    reg [23:0] sq[$];
    reg [7:0] sw [0:8] = '{8'hA2, 8'h82, 8'h00, 8'h86, 8'h04, 8'h42, 8'h10, 8'h23, 8'h8A};
    event rd_ev;
    cpu_machine_cycle_bus_sequencer u_cpu_machine_cycle_bus_sequencer (
        .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp), .ready(ready), .hold_req(hold_req),
        .irq_req(irq_req), .data_in(data_in), .addr_out(addr_out), .data_out(data_out),
        .data_oe(data_oe), .sync_out(sync_out), .data_in_strobe(data_in_strobe), .wr_n(wr_n),
        .wait_out(wait_out), .irq_enable_flag(irq_enable_flag));
    bus_partner u_bus_partner (
        .hclk(hclk), .hresetn(hresetn), .slow(slow), .rst_sel(rst_sel), .addr_out(addr_out),
        .data_out(data_out), .sync_out(sync_out), .wr_n(wr_n), .wait_out(wait_out),
        .ready(ready), .data_in(data_in), .wr_byte(wr_byte));
    initial begin
        hclk = 0;
        forever #5 hclk = ~hclk;
    end
    task chk(input [63:0] nm, input [31:0] seen, input [31:0] exp);
        begin
            num_checks = num_checks + 1;
            if (seen !== exp) begin
                failures = failures + 1;
                $display("FAIL %0s expected %h seen %h", nm, exp, seen);
            end
        end
    endtask
    task ahb(input w, input [7:0] a, input [31:0] d);
        begin
            htrans <= 2'h2;
            hwrite <= w;
            haddr <= {24'h0, a};
            @(posedge hclk);
            while (hreadyout !== 1'b1) @(posedge hclk);
            htrans <= 2'h0;
            hwdata <= d;
            @(posedge hclk);
            while (hreadyout !== 1'b1) @(posedge hclk);
            rv = hrdata;
        end
    endtask
    task rd(input [7:0] a, input [31:0] exp);
        begin
            rq.push_back(exp);
            ahb(0, a, 0);
            -> rd_ev;
        end
    endtask
    task poll(input integer b);
        begin
            i = 0;
            rv = 0;
            while (rv[b] !== 1'b1 && i < 300) begin
                ahb(0, `OFS_STATUS, 0);
                i = i + 1;
            end
            chk("poll", i < 300, 1);
        end
    endtask
    task run(input [7:0] cmd);
        begin
            ahb(1, `OFS_CMD, {24'h0, cmd});
            poll(`STAT_DONE);
            ahb(1, `OFS_STATUS, 32'h800);
        end
    endtask
    task final_report;
        begin
            $display("checks %0d mismatches %0d", num_checks, failures);
            if (failures == 0 && num_checks > 0)
                $display("NO MISMATCHES");
            else
                $display("MISMATCHES SEEN");
            $finish;
        end
    endtask
    always @(rd_ev) chk("register", rv, rq.pop_front());
    always @(negedge hclk) begin
        sync_d <= sync_out;
        if (sync_out === 1'b1 && sync_d !== 1'b1)
            chk("status", {8'h0, addr_out, data_out}, {8'h0, sq.pop_front()});
    end
    initial begin
        #300000;
        failures = failures + 1;
        final_report;
    end
    initial begin
        void'($urandom(33));
        {hresetn, hsel, hwrite, irq_req, hold_req, slow, sync_d} = 0;
        {haddr, hwdata, htrans, rst_sel} = 0;
        repeat (6) @(posedge hclk);
        hresetn <= 1;
        hsel <= 1;
        @(posedge hclk);
        rd(`OFS_CMD, 0);
        rd(`OFS_CTRL, 0);
        rd(`OFS_STATUS, 32'h1);
        rd(`OFS_PC, 0);
        rd(8'h40, 0);
        $display("test reset done");
        for (t = 0; t < 8; t = t + 1) begin
            pc = $urandom & 32'hFFFF;
            ad = $urandom & 32'hFFFF;
            wd = $urandom & 32'hFF;
            r = $urandom;
            hold_req <= r[2];
            // Odd kinds always wait, so the ready path through the wait state is always hit
            slow <= r[3] | t[0];
            rst_sel <= r[6:4];
            a16 = (t == 0 || t == 7) ? pc[15:0] : ad[15:0];
            ahb(1, `OFS_PC, pc);
            ahb(1, `OFS_ADDR, ad);
            ahb(1, `OFS_WDATA, wd);
            sq.push_back({a16, sw[t]});
            run({2'b00, r[1:0], t[3:0]});
            rd(`OFS_STATUS, {22'h0, hold_req, 9'h001});
            if (t == 7)
                rd(`OFS_RDATA, {26'h3, rst_sel, 3'h7});
            else if ((8'hAB >> t) & 1)
                rd(`OFS_RDATA, {24'h0, a16[7:0] ^ 8'h3C});
            else
                chk("wrbyte", wr_byte, wd);
            rd(`OFS_PC, t == 0 ? (pc + 1) & 32'hFFFF : pc);
        end
        $display("test cycle kinds done");
        {hold_req, slow} <= 0;
        ahb(1, `OFS_CTRL, 1);
        irq_req <= 1;
        sq.push_back({pc[15:0], 8'hA2});
        run(8'h40);
        rd(`OFS_STATUS, 32'h101);
        irq_req <= 0;
        pc = pc + 1;
        sq.push_back({pc[15:0], 8'h23});
        run(8'h00);
        rd(`OFS_CTRL, 0);
        rd(`OFS_PC, pc & 32'hFFFF);
        rd(`OFS_RDATA, {26'h3, rst_sel, 3'h7});
        $display("test interrupt done");
        ahb(1, `OFS_CTRL, 1);
        sq.push_back({ad[15:0], 8'h8A});
        ahb(1, `OFS_CMD, 8'h08);
        repeat (40) @(posedge hclk);
        chk("wait", wait_out, 1);
        irq_req <= 1;
        poll(`STAT_IRQ_LATCH);
        chk("wait", wait_out, 0);
        irq_req <= 0;
        ahb(1, `OFS_STATUS, 32'h800);
        sq.push_back({pc[15:0], 8'h23});
        run(8'h00);
        $display("test halt done");
        final_report;
    end
endmodule
